// *** hw/ccrb_pkg.sv ***
// Overview of operation
// R1: four separate control registers of 8, 8, 9 and 6 bits; each word updates exactly one.
// R2: word bits 10:9 select left, right, mode or format register.
// R3: host writes zero into bits 15:11 of every word.
// R4: host zeroes mode bit 6, format bits 8:6 and format bit 0.
// R5: apply bit 0 stores attenuation but keeps previously applied level.
// R6: apply bit 1 on either channel applies both stored levels together.
// R7: level 00h mutes, ffh is 0 dB default, scale value over 256.
// R8: left level sits at bits 7:0 of register zero, msb at 7.
// R9: shared level select uses left level for both channels.
// R10: adc sleep zeroes adc data, leaves dac and registers alone.
// R11: highpass skip 0 keeps filter, 1 bypasses it.
// R12: zero run detect mutes output after 65536 zero bit clocks.
// R13: output disable bit 3, emphasis bits 2:1, soft silence bit 0.
// R14: loopback bit 5, format select bits 4:2, frame polarity bit 1.
// R15: host shifts word msb first, raises latch after last rising clock.
// R16: output disable forces bipolar zero, keeps registers, restores on clear.
// R17: emphasis 00 off, 01 48 kHz, 10 44.1 kHz, 11 32 kHz.
// R18: soft silence mutes both channels inside digital filter.
// R19: reset loads levels ffh and clears every other control bit.
`default_nettype none
package ccrb_pkg;
  localparam int         WORD_W        = 16;
  localparam int         ADDR_HI       = 10;
  localparam int         ADDR_LO       = 9;
  localparam int         APPLY_BIT     = 8;
  localparam int         LEVEL_HI      = 7;
  localparam int         LEVEL_LO      = 0;
  localparam logic [1:0] SEL_LEFT      = 2'h0;
  localparam logic [1:0] SEL_RIGHT     = 2'h1;
  localparam logic [1:0] SEL_MODE      = 2'h2;
  localparam logic [1:0] SEL_FORMAT    = 2'h3;
  localparam int         MODE_SLEEP    = 8;
  localparam int         MODE_HPSKIP   = 7;
  localparam int         MODE_SHARED   = 5;
  localparam int         MODE_ZDET     = 4;
  localparam int         MODE_OUTDIS   = 3;
  localparam int         MODE_EMPH_HI  = 2;
  localparam int         MODE_EMPH_LO  = 1;
  localparam int         MODE_SILENCE  = 0;
  localparam int         FMT_LOOP      = 5;
  localparam int         FMT_SEL_HI    = 4;
  localparam int         FMT_SEL_LO    = 2;
  localparam int         FMT_POL       = 1;
  localparam logic [7:0] LEVEL_RESET   = 8'hff;
  localparam logic [7:0] LEVEL_MUTE    = 8'h00;
  localparam logic [8:0] MODE_RESET    = 9'h000;
  localparam logic [5:0] FORMAT_RESET  = 6'h00;
  localparam logic [1:0] EMPH_OFF      = 2'h0;
  localparam logic [1:0] EMPH_48K      = 2'h1;
  localparam logic [1:0] EMPH_44K1     = 2'h2;
  localparam logic [1:0] EMPH_32K      = 2'h3;
  localparam int         ZERO_RUN      = 65536;
  localparam int         ZCNT_W        = 17;
  localparam logic [4:0] SHIFT_CNT_MAX = 5'h10;
endpackage
`default_nettype wire

// *** hw/ccrb_word_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// carries one assembled control word from the shifter to the bank
interface ccrb_word_if;
  logic        valid;
  logic [15:0] word;
  modport src (output valid, output word);
  modport dst (input valid, input word);
endinterface
`default_nettype wire

// *** hw/ccrb_shifter.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccrb_shifter (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // synchronised serial pins
  input  wire logic sclk_s_i,
  input  wire logic sdat_s_i,
  input  wire logic latch_s_i,
  // assembled word
  ccrb_word_if.src  out
);
  logic [15:0] shift_q, shift_d;
  logic        sclk_q, sclk_d;
  logic        latch_q, latch_d;
  logic        valid_q, valid_d;
  logic [15:0] word_q, word_d;

  always_comb begin
    shift_d = shift_q;
    sclk_d  = sclk_s_i;
    latch_d = latch_s_i;
    valid_d = 1'b0;
    word_d  = word_q;
    // msb first, bit taken on each rising shift clock R15
    if (sclk_s_i && !sclk_q) begin
      shift_d = {shift_q[14:0], sdat_s_i};
    end
    // rising latch hands over the last sixteen bits R15
    if (latch_s_i && !latch_q) begin
      valid_d = 1'b1;
      word_d  = shift_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      shift_q <= 16'h0000;
      sclk_q  <= 1'b0;
      latch_q <= 1'b1;
      valid_q <= 1'b0;
      word_q  <= 16'h0000;
    end else begin
      shift_q <= shift_d;
      sclk_q  <= sclk_d;
      latch_q <= latch_d;
      valid_q <= valid_d;
      word_q  <= word_d;
    end
  end

  assign out.valid = valid_q;
  assign out.word  = word_q;
endmodule
`default_nettype wire

// *** hw/ccrb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccrb_top (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  // serial control pins
  input  wire logic       control_shift_clock_i,
  input  wire logic       control_serial_in_i,
  input  wire logic       control_word_latch_i,
  // zero detection input
  input  wire logic       bit_clock_in_i,
  input  wire logic       dac_input_zero_i,
  // applied dac levels and dac controls
  output logic [7:0]      left_level_o,
  output logic [7:0]      right_level_o,
  output logic            dac_bipolar_zero_o,
  output logic            dac_amp_disconnect_o,
  output logic            soft_silence_o,
  output logic [1:0]      emphasis_curve_select_o,
  output logic            emph_48k_o,
  output logic            emph_44k1_o,
  output logic            emph_32k_o,
  // adc controls
  output logic            adc_sleep_o,
  output logic            adc_data_force_zero_o,
  output logic            highpass_skip_o,
  output logic            highpass_active_o,
  // format controls
  output logic            adc_to_dac_loop_o,
  output logic [2:0]      serial_format_select_o,
  output logic            frame_clock_polarity_o
);
  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [4:0] sync1_q, sync2_q;
  logic [4:0] sync_in;
  assign sync_in = {control_shift_clock_i, control_serial_in_i, control_word_latch_i,
                    bit_clock_in_i, dac_input_zero_i};

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sync1_q <= 5'h04;
      sync2_q <= 5'h04;
    end else begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // serial word assembly
  // ==========================================================
  ccrb_word_if wbus ();

  ccrb_shifter u_shifter (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .sclk_s_i  (sync2_q[4]),
    .sdat_s_i  (sync2_q[3]),
    .latch_s_i (sync2_q[2]),
    .out       (wbus)
  );

  // ==========================================================
  // register bank
  // ==========================================================
  logic [7:0] left_store_q, left_store_d;
  logic [7:0] right_store_q, right_store_d;
  logic [7:0] left_applied_q, left_applied_d;
  logic [7:0] right_applied_q, right_applied_d;
  logic [8:0] mode_q, mode_d;
  logic [5:0] format_q, format_d;
  logic [1:0] sel;
  logic       apply;

  assign sel   = wbus.word[ccrb_pkg::ADDR_HI:ccrb_pkg::ADDR_LO]; // R2
  assign apply = wbus.word[ccrb_pkg::APPLY_BIT];

  always_comb begin
    left_store_d    = left_store_q;
    right_store_d   = right_store_q;
    left_applied_d  = left_applied_q;
    right_applied_d = right_applied_q;
    mode_d          = mode_q;
    format_d        = format_q;
    // reserved bits 15:11 are not checked; host keeps them zero R3
    if (wbus.valid) begin
      // one word touches exactly one register R1
      if (sel == ccrb_pkg::SEL_LEFT) begin
        left_store_d = wbus.word[ccrb_pkg::LEVEL_HI:ccrb_pkg::LEVEL_LO]; // R8
      end else if (sel == ccrb_pkg::SEL_RIGHT) begin
        right_store_d = wbus.word[ccrb_pkg::LEVEL_HI:ccrb_pkg::LEVEL_LO];
      end else if (sel == ccrb_pkg::SEL_MODE) begin
        // bit 6 stored as written; host zeroes it R4
        mode_d = wbus.word[8:0];
      end else begin
        // bit 0 stored as written, bits 8:6 not stored R4
        format_d = wbus.word[5:0];
      end
      // apply both stored levels together, new word included R5 R6
      if (apply && (sel == ccrb_pkg::SEL_LEFT || sel == ccrb_pkg::SEL_RIGHT)) begin
        left_applied_d  = (sel == ccrb_pkg::SEL_LEFT) ? left_store_d : left_store_q;
        right_applied_d = (sel == ccrb_pkg::SEL_RIGHT) ? right_store_d : right_store_q;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      // R19
      left_store_q    <= ccrb_pkg::LEVEL_RESET;
      right_store_q   <= ccrb_pkg::LEVEL_RESET;
      left_applied_q  <= ccrb_pkg::LEVEL_RESET;
      right_applied_q <= ccrb_pkg::LEVEL_RESET;
      mode_q          <= ccrb_pkg::MODE_RESET;
      format_q        <= ccrb_pkg::FORMAT_RESET;
    end else begin
      left_store_q    <= left_store_d;
      right_store_q   <= right_store_d;
      left_applied_q  <= left_applied_d;
      right_applied_q <= right_applied_d;
      mode_q          <= mode_d;
      format_q        <= format_d;
    end
  end

  // ==========================================================
  // zero run detection on bit clock edges
  // ==========================================================
  logic [16:0] zcnt_q, zcnt_d;
  logic        bck_q, bck_d;
  logic        zmute_q, zmute_d;

  always_comb begin
    bck_d   = sync2_q[1];
    zcnt_d  = zcnt_q;
    zmute_d = zmute_q;
    if (!mode_q[ccrb_pkg::MODE_ZDET] || !sync2_q[0]) begin
      zcnt_d  = 17'h00000;
      zmute_d = 1'b0;
    end else if (sync2_q[1] && !bck_q) begin
      // count holds at ZERO_RUN - 1; the next edge sets the mute R12
      if (zcnt_q == 17'(ccrb_pkg::ZERO_RUN - 1)) begin
        zmute_d = 1'b1;
      end else begin
        zcnt_d = zcnt_q + 17'h00001;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      zcnt_q  <= 17'h00000;
      bck_q   <= 1'b0;
      zmute_q <= 1'b0;
    end else begin
      zcnt_q  <= zcnt_d;
      bck_q   <= bck_d;
      zmute_q <= zmute_d;
    end
  end

  // ==========================================================
  // control outputs
  // ==========================================================
  logic [7:0] left_out_q, left_out_d;
  logic [7:0] right_out_q, right_out_d;

  always_comb begin
    left_out_d  = left_applied_q; // R7
    // shared mode ignores the right level R9
    right_out_d = mode_q[ccrb_pkg::MODE_SHARED] ? left_applied_q : right_applied_q;
    // silence attenuates both together in the filter R18
    if (mode_q[ccrb_pkg::MODE_SILENCE]) begin
      left_out_d  = ccrb_pkg::LEVEL_MUTE;
      right_out_d = ccrb_pkg::LEVEL_MUTE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      left_out_q  <= ccrb_pkg::LEVEL_RESET;
      right_out_q <= ccrb_pkg::LEVEL_RESET;
    end else begin
      left_out_q  <= left_out_d;
      right_out_q <= right_out_d;
    end
  end

  assign left_level_o  = left_out_q;
  assign right_level_o = right_out_q;
  // registers untouched, so clearing restores the old state R16 R13
  assign dac_bipolar_zero_o      = mode_q[ccrb_pkg::MODE_OUTDIS];
  assign dac_amp_disconnect_o    = zmute_q; // R12
  assign soft_silence_o          = mode_q[ccrb_pkg::MODE_SILENCE]; // R13
  assign emphasis_curve_select_o = mode_q[ccrb_pkg::MODE_EMPH_HI:ccrb_pkg::MODE_EMPH_LO];
  // R17
  assign emph_48k_o  = (emphasis_curve_select_o == ccrb_pkg::EMPH_48K);
  assign emph_44k1_o = (emphasis_curve_select_o == ccrb_pkg::EMPH_44K1);
  assign emph_32k_o  = (emphasis_curve_select_o == ccrb_pkg::EMPH_32K);
  // R10
  assign adc_sleep_o           = mode_q[ccrb_pkg::MODE_SLEEP];
  assign adc_data_force_zero_o = mode_q[ccrb_pkg::MODE_SLEEP];
  // R11
  assign highpass_skip_o   = mode_q[ccrb_pkg::MODE_HPSKIP];
  assign highpass_active_o = !mode_q[ccrb_pkg::MODE_HPSKIP];
  // R14
  assign adc_to_dac_loop_o      = format_q[ccrb_pkg::FMT_LOOP];
  assign serial_format_select_o = format_q[ccrb_pkg::FMT_SEL_HI:ccrb_pkg::FMT_SEL_LO];
  assign frame_clock_polarity_o = format_q[ccrb_pkg::FMT_POL];
endmodule
`default_nettype wire

// *** tb/ccrb_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccrb_checker (
  // clock and reset
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  // watched pins
  input wire logic       control_word_latch_i,
  input wire logic       dac_input_zero_i,
  input wire logic [7:0] left_level_o,
  input wire logic [7:0] right_level_o,
  input wire logic       dac_bipolar_zero_o,
  input wire logic       dac_amp_disconnect_o,
  input wire logic       soft_silence_o,
  input wire logic [1:0] emphasis_curve_select_o,
  input wire logic       emph_48k_o,
  input wire logic       emph_44k1_o,
  input wire logic       emph_32k_o,
  input wire logic       adc_sleep_o,
  input wire logic       adc_data_force_zero_o,
  input wire logic       highpass_skip_o,
  input wire logic       highpass_active_o,
  input wire logic       adc_to_dac_loop_o,
  input wire logic [2:0] serial_format_select_o,
  input wire logic       frame_clock_polarity_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========
  // sequences
  // eight cycles cover the whole pin-to-output pipeline
  sequence latch_quiet;
    (!$rose(control_word_latch_i)) [*8];
  endsequence
  sequence level_quiet;
    (!$rose(control_word_latch_i) && !soft_silence_o) [*8];
  endsequence
  // ==========
  // assertions
  AST_RESET_VAL:
    assert property ($rose(reset_n_i) |-> left_level_o == 8'hff && right_level_o == 8'hff
      && !adc_sleep_o && !soft_silence_o && highpass_active_o) else $error("reset value");
  AST_MODE_HOLD:
    assert property (latch_quiet |-> $stable({adc_sleep_o, highpass_skip_o, dac_bipolar_zero_o,
      emphasis_curve_select_o, soft_silence_o, adc_to_dac_loop_o, serial_format_select_o,
      frame_clock_polarity_o})) else $error("control moved without latch");
  AST_LEVEL_HOLD:
    assert property (level_quiet |-> $stable(left_level_o) && $stable(right_level_o))
      else $error("level moved without latch");
  AST_SILENCE:
    assert property (soft_silence_o |=> left_level_o == 8'h00 && right_level_o == 8'h00)
      else $error("silence not muting");
  AST_HP_INV:
    assert property (highpass_active_o != highpass_skip_o) else $error("highpass pair");
  AST_SLEEP:
    assert property (adc_data_force_zero_o == adc_sleep_o) else $error("adc zero");
  AST_E48:
    assert property (emph_48k_o == (emphasis_curve_select_o == 2'h1)) else $error("e48");
  AST_E44:
    assert property (emph_44k1_o == (emphasis_curve_select_o == 2'h2)) else $error("e44");
  AST_E32:
    assert property (emph_32k_o == (emphasis_curve_select_o == 2'h3)) else $error("e32");
  AST_AMP:
    assert property ((!dac_input_zero_i) [*4] |-> !dac_amp_disconnect_o) else $error("amp");
endmodule
bind ccrb_top ccrb_checker i_ccrb_checker (.sys_clk_i, .reset_n_i, .control_word_latch_i,
  .dac_input_zero_i, .left_level_o, .right_level_o, .dac_bipolar_zero_o, .dac_amp_disconnect_o,
  .soft_silence_o, .emphasis_curve_select_o, .emph_48k_o, .emph_44k1_o, .emph_32k_o,
  .adc_sleep_o, .adc_data_force_zero_o, .highpass_skip_o, .highpass_active_o,
  .adc_to_dac_loop_o, .serial_format_select_o, .frame_clock_polarity_o);
`default_nettype wire

// *** tb/ccrb_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccrb_host (
  // clock
  input  wire logic sys_clk_i,
  // serial control pins
  output var logic  shift_clock_o,
  output var logic  serial_data_o,
  output var logic  latch_o
);
  // latch idles high so reset release does not count as a rise
  initial begin
    shift_clock_o = 1'b0;
    serial_data_o = 1'b0;
    latch_o       = 1'b1;
  end
  // four cycles keeps every level past the two-flop synchroniser
  task automatic hold();
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic send(input logic [15:0] w);
    latch_o = 1'b0;
    hold();
    for (int i = 15; i >= 0; i--) begin
      serial_data_o = w[i];
      shift_clock_o = 1'b0;
      hold();
      shift_clock_o = 1'b1;
      hold();
    end
    latch_o = 1'b1;
    hold();
    shift_clock_o = 1'b0;
    serial_data_o = !w[0];
  endtask
endmodule
`default_nettype wire

// *** tb/test_codec_control_register_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_codec_control_register_bank;
  logic       sys_clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       control_shift_clock_i, control_serial_in_i, control_word_latch_i;
  logic [7:0] left_level_o, right_level_o;
  logic [1:0] emphasis_curve_select_o;
  logic [2:0] serial_format_select_o;
  logic       dac_bipolar_zero_o, dac_amp_disconnect_o, soft_silence_o, emph_48k_o;
  logic       emph_44k1_o, emph_32k_o, adc_sleep_o, adc_data_force_zero_o;
  logic       highpass_skip_o, highpass_active_o, adc_to_dac_loop_o, frame_clock_polarity_o;
  int         n_fail = 0;
  int         total_checks = 0;
  logic       bit_clock_in_i = 1'b0;
  logic       dac_input_zero_i = 1'b0;
  // a full zero run is beyond the run budget, so the count is followed instead
  ccrb_top i_ccrb_top (.sys_clk_i, .reset_n_i, .control_shift_clock_i, .control_serial_in_i,
    .control_word_latch_i, .bit_clock_in_i, .dac_input_zero_i, .left_level_o,
    .right_level_o, .dac_bipolar_zero_o, .dac_amp_disconnect_o, .soft_silence_o,
    .emphasis_curve_select_o, .emph_48k_o, .emph_44k1_o, .emph_32k_o, .adc_sleep_o,
    .adc_data_force_zero_o, .highpass_skip_o, .highpass_active_o, .adc_to_dac_loop_o,
    .serial_format_select_o, .frame_clock_polarity_o);
  ccrb_host i_ccrb_host (.sys_clk_i, .shift_clock_o(control_shift_clock_i),
    .serial_data_o(control_serial_in_i), .latch_o(control_word_latch_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
  // ==========
  // helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [8:0] val);
    i_ccrb_host.send({5'h00, sel, val});
    repeat (10) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic lv(input logic [15:0] exp);
    chk("levels", exp, {left_level_o, right_level_o});
  endtask
  function automatic logic [15:0] modev();
    return {6'h00, adc_sleep_o, adc_data_force_zero_o, highpass_skip_o, highpass_active_o,
      dac_bipolar_zero_o, emphasis_curve_select_o, emph_48k_o, emph_44k1_o, emph_32k_o};
  endfunction
  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    lv(16'hffff);
    chk("mode", 16'h0040, modev());
    chk("fmt", 16'h0000,
      {11'h000, adc_to_dac_loop_o, serial_format_select_o, frame_clock_polarity_o});
    chk("amp", 16'h0000, {15'h0000, dac_amp_disconnect_o});
    chk("silence", 16'h0000, {15'h0000, soft_silence_o});
  endtask
  task automatic t_mode();
    for (int e = 0; e < 4; e++) begin
      wr(ccrb_pkg::SEL_MODE, {e[0], ~e[0], 3'b000, e[1], e[1:0], 1'b0});
      chk("mode", {6'h00, e[0], e[0], ~e[0], e[0], e[1], e[1:0], e == 1, e == 2, e == 3},
        modev());
      lv(16'hffff);
    end
    wr(ccrb_pkg::SEL_MODE, 9'h000);
  endtask
  task automatic t_format();
    for (int k = 0; k < 7; k++) begin
      wr(ccrb_pkg::SEL_FORMAT, {3'b000, k[0], k[2:0], ~k[0], 1'b0});
      chk("fmt", {11'h000, k[0], k[2:0], ~k[0]},
        {11'h000, adc_to_dac_loop_o, serial_format_select_o, frame_clock_polarity_o});
      chk("mode", 16'h0040, modev());
    end
  endtask
  task automatic t_levels();
    wr(ccrb_pkg::SEL_LEFT, {1'b0, 8'h5a});
    lv(16'hffff);
    wr(ccrb_pkg::SEL_RIGHT, {1'b1, 8'h3c});
    lv(16'h5a3c);
    wr(ccrb_pkg::SEL_RIGHT, {1'b0, 8'hc3});
    wr(ccrb_pkg::SEL_LEFT, {1'b1, 8'h00});
    lv(16'h00c3);
    wr(ccrb_pkg::SEL_MODE, 9'h001);
    lv(16'h0000);
    chk("silence", 16'h0001, {15'h0000, soft_silence_o});
    wr(ccrb_pkg::SEL_MODE, 9'h000);
    lv(16'h00c3);
  endtask
  task automatic t_shared();
    wr(ccrb_pkg::SEL_LEFT, {1'b1, 8'h81});
    wr(ccrb_pkg::SEL_MODE, 9'h020);
    lv(16'h8181);
    wr(ccrb_pkg::SEL_RIGHT, {1'b1, 8'h11});
    lv(16'h8181);
    wr(ccrb_pkg::SEL_MODE, 9'h000);
  endtask
  task automatic t_zero();
    dac_input_zero_i = 1'b1;
    wr(ccrb_pkg::SEL_MODE, 9'h010);
    // three cycles a level keeps every bit clock edge past the synchroniser
    for (int n = 0; n < 2000; n++) begin
      bit_clock_in_i = ~bit_clock_in_i;
      repeat (3) @(posedge sys_clk_i);
      #1;
    end
    chk("zero count", 16'h03e8, i_ccrb_top.zcnt_q[15:0]);
    chk("amp", 16'h0000, {15'h0000, dac_amp_disconnect_o});
    dac_input_zero_i = 1'b0;
    wr(ccrb_pkg::SEL_MODE, 9'h000);
    chk("zero count", 16'h0000, i_ccrb_top.zcnt_q[15:0]);
  endtask
  task automatic t_rerun();
    wr(ccrb_pkg::SEL_FORMAT, 9'h024);
    reset_n_i = 1'b0;
    repeat (16) @(posedge sys_clk_i);
    #1 reset_n_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    t_reset();
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    #1 reset_n_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    t_reset();
    t_mode();
    t_format();
    t_levels();
    t_shared();
    t_zero();
    t_rerun();
    finish_test();
  end
endmodule
`default_nettype wire
